// File: design/inactivity_watchdog_map.vh
// Register map, field positions, reset values and timing for the watchdog.
// Assumes inclusion by bare name from the design modules.
`ifndef INACTIVITY_WATCHDOG_MAP_VH
`define INACTIVITY_WATCHDOG_MAP_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define WD_IDX_TIMEOUT      4'h0
`define WD_IDX_MASK         4'h1
`define WD_IDX_STATUS       4'h2
`define WD_IDX_RESERVED     4'h3
`define WD_IDX_IRQ_STATUS   4'h4
`define WD_IDX_IRQ_MASK     4'h5

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define WD_MASK_UART2_BIT   3
`define WD_MASK_UART1_BIT   2
`define WD_MASK_WRITABLE    8'h0c
`define WD_STATUS_ALARM_BIT 0
`define WD_TIMEOUT_RESET    8'h00
`define WD_MASK_RESET       8'h00
`define WD_STATUS_RESET     8'h01
`define WD_IRQ_EXPIRED_BIT  0
`define WD_IRQ_WRITABLE     8'h01

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define WD_TICK_SECONDS     60
`define WD_CLK_HZ           10000000
`define WD_TICK_CYCLES      (`WD_TICK_SECONDS * `WD_CLK_HZ)

`endif

// File: design/minute_prescaler.v
// One-cycle tick generator dividing the device clock down to the minute.
// Assumes a free-running clock and a synchronous active-low reset.
`timescale 1ns/1ns
`include "inactivity_watchdog_map.vh"

module minute_prescaler
#(
	parameter TICK_CYCLES = `WD_TICK_CYCLES
)
(
	input  wire sys_clk,  // Device clock
	input  wire resetn,   // Synchronous reset, active low
	input  wire restart,  // Restart the minute from zero
	output reg  tick      // One-cycle pulse per period
);

	reg [31:0] count_q;

	// ------------------------------------------------------------
	// Divider
	// ------------------------------------------------------------
	// Restart realigns the minute so a reload gets a full period
	always @(posedge sys_clk)
	begin
		if (!resetn || restart)
		begin
			count_q <= 32'h0;
			tick    <= 1'b0;
		end
		else if (count_q == TICK_CYCLES - 1)
		begin
			count_q <= 32'h0;
			tick    <= 1'b1;
		end
		else
		begin
			count_q <= count_q + 32'h1;
			tick    <= 1'b0;
		end
	end

endmodule // minute_prescaler

// File: design/inactivity_watchdog_timer.v
// Inactivity watchdog with an AXI4-Lite register slave.
// Assumes serial-port requests synchronous or asynchronous; they are
// synchronised here. One clock, synchronous active-low reset.
// The minute is TICK_CYCLES clocks, so the default suits 10 MHz only.
// Byte address is four times the register index; only the low byte of
// each word carries data. The alarm pin is push-pull: routing it to an
// interrupt line or an open-drain pad is left to the surroundings.
`timescale 1ns/1ns
`include "inactivity_watchdog_map.vh"

module inactivity_watchdog_timer
#(
	parameter TICK_CYCLES = `WD_TICK_CYCLES
)
(
	input  wire        sys_clk,        // Device clock, 10 MHz
	input  wire        resetn,         // Synchronous reset, active low
	input  wire [5:0]  s_axi_awaddr,   // Write address
	input  wire        s_axi_awvalid,  // Write address valid
	output wire        s_axi_awready,  // Write address ready
	input  wire [31:0] s_axi_wdata,    // Write data
	input  wire [3:0]  s_axi_wstrb,    // Write byte strobes
	input  wire        s_axi_wvalid,   // Write data valid
	output wire        s_axi_wready,   // Write data ready
	output reg  [1:0]  s_axi_bresp,    // Write response
	output reg         s_axi_bvalid,   // Write response valid
	input  wire        s_axi_bready,   // Write response ready
	input  wire [5:0]  s_axi_araddr,   // Read address
	input  wire        s_axi_arvalid,  // Read address valid
	output wire        s_axi_arready,  // Read address ready
	output reg  [31:0] s_axi_rdata,    // Read data
	output reg  [1:0]  s_axi_rresp,    // Read response
	output reg         s_axi_rvalid,   // Read data valid
	input  wire        s_axi_rready,   // Read data ready
	input  wire        uart1Irq,       // First serial port request
	input  wire        uart2Irq,       // Second serial port request
	output reg         alarm_out_n,    // Alarm, active low
	output wire        wdIrq,          // Watchdog request, active high
	output wire        irq             // Masked sticky event interrupt
);

	localparam [1:0] RESP_OKAY   = 2'b00;
	localparam [1:0] RESP_SLVERR = 2'b10;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	reg  [7:0]  timeout_minutes_q;
	reg  [7:0]  trigger_mask_q;
	reg  [7:0]  count_q;
	reg         running_q;
	reg  [7:0]  irqStatus_q;
	reg  [7:0]  irqMask_q;
	reg  [1:0]  uart1Sync_q;
	reg  [1:0]  uart2Sync_q;
	// Write halves held until both have arrived
	reg         awHeld_q;
	reg  [5:0]  awAddr_q;
	reg         wHeld_q;
	reg  [31:0] wData_q;
	reg  [3:0]  wStrb_q;

	// Decode and handshake nets
	wire        tick;
	wire        trigger;
	wire        doWrite;
	wire [3:0]  wrIdx;
	wire        toWrite;
	wire        expire;
	wire [7:0]  alarm_status;
	wire        restart;
	wire        irqClear;

	// Word index of a byte address; misaligned addresses are unmapped
	function [4:0] word_index;
		input [5:0] addr;
		begin
			word_index = {addr[1:0] != 2'b00, addr[5:2]};
		end
	endfunction

	// Strobe for one aligned register whose low byte is enabled
	function reg_write;
		input       fire;
		input [5:0] addr;
		input [3:0] strb;
		input [3:0] idx;
		begin
			reg_write = fire && strb[0] && addr[1:0] == 2'b00 &&
				addr[5:2] == idx;
		end
	endfunction

	// ------------------------------------------------------------
	// Write channel
	// ------------------------------------------------------------
	// Address and data are latched independently, in either order
	assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
	assign s_axi_wready  = !wHeld_q && !s_axi_bvalid;
	assign doWrite       = awHeld_q && wHeld_q && !s_axi_bvalid;
	assign wrIdx         = awAddr_q[5:2];
	assign toWrite       = reg_write(doWrite, awAddr_q, wStrb_q,
		`WD_IDX_TIMEOUT);
	assign irqClear      = reg_write(doWrite, awAddr_q, wStrb_q,
		`WD_IDX_IRQ_STATUS);

	always @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			awHeld_q     <= 1'b0;
			awAddr_q     <= 6'h00;
			wHeld_q      <= 1'b0;
			wData_q      <= 32'h0;
			wStrb_q      <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHeld_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHeld_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
			if (doWrite)
			begin
				awHeld_q     <= 1'b0;
				wHeld_q      <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// Reserved index and holes answer SLVERR
				if (word_index(awAddr_q) > {1'b0, `WD_IDX_IRQ_MASK} ||
					word_index(awAddr_q) == {1'b0, `WD_IDX_RESERVED})
					s_axi_bresp <= RESP_SLVERR;
				else
					s_axi_bresp <= RESP_OKAY;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------
	// Status register writes fall through silently: it is read-only
	// Mask keeps only its two trigger bits; reserved bits read zero
	always @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			timeout_minutes_q <= `WD_TIMEOUT_RESET;
			trigger_mask_q    <= `WD_MASK_RESET;
			irqMask_q         <= 8'h00;
		end
		else if (doWrite && wStrb_q[0] && awAddr_q[1:0] == 2'b00)
		begin
			case (wrIdx)
				`WD_IDX_TIMEOUT:
					timeout_minutes_q <= wData_q[7:0];
				`WD_IDX_MASK:
					trigger_mask_q <= wData_q[7:0] &
						`WD_MASK_WRITABLE;
				`WD_IDX_IRQ_MASK:
					irqMask_q <= wData_q[7:0] & `WD_IRQ_WRITABLE;
				default:
					irqMask_q <= irqMask_q;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Trigger inputs
	// ------------------------------------------------------------
	// Requests come from other blocks; two flops before any use
	always @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			uart1Sync_q <= 2'b00;
			uart2Sync_q <= 2'b00;
		end
		else
		begin
			uart1Sync_q <= {uart1Sync_q[0], uart1Irq};
			uart2Sync_q <= {uart2Sync_q[0], uart2Irq};
		end
	end

	// An active level retriggers each cycle, as the request is a level
	assign trigger =
		(uart2Sync_q[1] && trigger_mask_q[`WD_MASK_UART2_BIT]) ||
		(uart1Sync_q[1] && trigger_mask_q[`WD_MASK_UART1_BIT]);

	// ------------------------------------------------------------
	// Countdown
	// ------------------------------------------------------------
	// A reload of any kind also realigns the minute
	assign restart = toWrite || (running_q && trigger);

	minute_prescaler
	#(
		.TICK_CYCLES (TICK_CYCLES)
	)
	u_prescaler
	(
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.restart (restart),
		.tick    (tick)
	);

	// Expiry follows the countdown's own priority: a timeout write or
	// a trigger in the same cycle reloads the counter instead, so the
	// sticky event bit must not be set either
	assign expire = running_q && !toWrite && !trigger && tick &&
		count_q == 8'h01;

	// Write beats trigger; trigger beats the minute tick
	always @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			count_q     <= 8'h00;
			running_q   <= 1'b0;
			alarm_out_n <= 1'b1;
		end
		else if (toWrite)
		begin
			alarm_out_n <= 1'b1;
			count_q     <= wData_q[7:0];
			running_q   <= wData_q[7:0] != 8'h00;
		end
		else if (running_q && trigger)
			count_q <= timeout_minutes_q;
		else if (running_q && tick)
		begin
			count_q <= count_q - 8'h01;
			if (count_q == 8'h01)
			begin
				running_q   <= 1'b0;
				alarm_out_n <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Alarm outputs
	// ------------------------------------------------------------
	// Wired from the pin register, so status can never drift from it
	// Status bit mirrors the alarm level, 01h whenever inactive
	assign alarm_status = {7'h00, alarm_out_n};
	assign wdIrq        = !alarm_out_n;

	// ------------------------------------------------------------
	// Interrupt status
	// ------------------------------------------------------------
	// Expiry sets the sticky bit; a set outranks a same-cycle clear
	always @(posedge sys_clk)
	begin
		if (!resetn)
			irqStatus_q <= 8'h00;
		else
		begin
			if (irqClear)
				irqStatus_q <= irqStatus_q & ~(wData_q[7:0] &
					`WD_IRQ_WRITABLE);
			if (expire)
				irqStatus_q[`WD_IRQ_EXPIRED_BIT] <= 1'b1;
		end
	end

	// Level output, high while any unmasked event bit is set
	assign irq = |(irqStatus_q & irqMask_q);

	// ------------------------------------------------------------
	// Read channel
	// ------------------------------------------------------------
	// One read outstanding; the next address waits for the answer
	assign s_axi_arready = !s_axi_rvalid;

	// Unmapped and misaligned reads answer SLVERR with zero data
	always @(posedge sys_clk)
	begin
		if (!resetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= RESP_OKAY;
			case (word_index(s_axi_araddr))
				{1'b0, `WD_IDX_TIMEOUT}:
					s_axi_rdata <= {24'h0, timeout_minutes_q};
				{1'b0, `WD_IDX_MASK}:
					s_axi_rdata <= {24'h0, trigger_mask_q};
				{1'b0, `WD_IDX_STATUS}:
					s_axi_rdata <= {24'h0, alarm_status};
				{1'b0, `WD_IDX_IRQ_STATUS}:
					s_axi_rdata <= {24'h0, irqStatus_q};
				{1'b0, `WD_IDX_IRQ_MASK}:
					s_axi_rdata <= {24'h0, irqMask_q};
				default:
				begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

endmodule // inactivity_watchdog_timer

// File: tb/inactivity_watchdog_timer_sva.sv
// Port assertions for the inactivity watchdog.
// Assumes binding onto the top module; one clock domain.
`timescale 1ns/1ns
module watchdog_checker
#(
	parameter TICK_CYCLES = 20
)
(
	input wire        sys_clk,       // Clock
	input wire        resetn,        // Reset, active low
	input wire        s_axi_awvalid, // AW valid
	input wire        s_axi_wvalid,  // W valid
	input wire        s_axi_bvalid,  // B valid
	input wire        s_axi_bready,  // B ready
	input wire [5:0]  s_axi_araddr,  // AR address
	input wire        s_axi_arvalid, // AR valid
	input wire        s_axi_arready, // AR ready
	input wire [31:0] s_axi_rdata,   // Read data
	input wire [1:0]  s_axi_rresp,   // Read response
	input wire        s_axi_rvalid,  // R valid
	input wire        s_axi_rready,  // R ready
	input wire        uart1Irq,      // Serial request 1
	input wire        uart2Irq,      // Serial request 2
	input wire        alarm_out_n,   // Alarm, active low
	input wire        wdIrq          // Watchdog request
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	reg [31:0] quiet_q;
	reg        bvalid_q;
	// Cycles since the last write answer; requests are left out, as
	// the mask is not seen here and a masked one reloads nothing
	always @(posedge sys_clk)
	begin
		bvalid_q <= s_axi_bvalid;
		if (!resetn || (s_axi_bvalid && !bvalid_q))
			quiet_q <= 32'h0;
		else if (quiet_q != 32'hffffffff)
			quiet_q <= quiet_q + 32'h1;
	end
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	a_irq_tracks_alarm:
	assert property (wdIrq == !alarm_out_n) else $error("wdIrq off");
	a_alarm_held_low:
	assert property (!alarm_out_n && !s_axi_awvalid && !s_axi_wvalid &&
		!$past(s_axi_awvalid) && !$past(s_axi_wvalid) |=> !alarm_out_n)
		else $error("alarm released without write");
	a_release_by_write:
	assert property ($rose(alarm_out_n) |-> $rose(s_axi_bvalid))
		else $error("alarm released off a write");
	a_alarm_after_minute:
	assert property ($fell(alarm_out_n) |-> quiet_q >= TICK_CYCLES - 3)
		else $error("alarm too early");
	a_reserved_error:
	assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 6'h0c
		|=> s_axi_rvalid && s_axi_rresp == 2'b10) else $error("no slverr");
	a_status_mirror:
	assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 6'h08
		|=> s_axi_rdata == {31'h0, $past(alarm_out_n)})
		else $error("status differs from alarm");
	a_rvalid_holds:
	assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
		$stable(s_axi_rdata)) else $error("read answer dropped");
	a_bvalid_holds:
	assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	a_read_blocked:
	assert property (s_axi_rvalid |-> !s_axi_arready) else $error("arready");
	c_expire: cover property ($fell(alarm_out_n));
	c_trigger: cover property (alarm_out_n && (uart1Irq || uart2Irq));
	c_reserved: cover property (s_axi_arvalid && s_axi_araddr == 6'h0c);
endmodule // watchdog_checker
bind inactivity_watchdog_timer watchdog_checker #(.TICK_CYCLES(TICK_CYCLES))
	chk (.sys_clk, .resetn, .s_axi_awvalid, .s_axi_wvalid, .s_axi_bvalid,
	.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .uart1Irq,
	.uart2Irq, .alarm_out_n, .wdIrq);

// File: tb/host_alarm_sink.sv
// Host interrupt logic model: counts watchdog prompts.
// Assumes request and alarm pin are levels on one clock.
`timescale 1ns/1ns
module host_alarm_sink
(
	input  wire       sys_clk,     // Clock
	input  wire       resetn,      // Reset, active low
	input  wire       alarm_out_n, // Alarm pin
	input  wire       wdIrq,       // Watchdog request
	output reg  [7:0] promptCnt_q  // Prompts seen
);
	reg prev_q;
	// One count per new prompt; pin must agree with request
	always @(posedge sys_clk)
	begin
		prev_q <= wdIrq;
		if (!resetn)
			promptCnt_q <= 8'h00;
		else if (wdIrq && !prev_q && !alarm_out_n)
			promptCnt_q <= promptCnt_q + 8'h01;
	end
endmodule // host_alarm_sink

// File: tb/test_inactivity_watchdog_timer.sv
// Self-checking bench for the inactivity watchdog.
// Assumes a shortened minute of TICK cycles at 10 MHz.
`timescale 1ns/1ns
module test_inactivity_watchdog_timer;
	localparam TICK = 20;
	reg         sys_clk, resetn, s_axi_awvalid, s_axi_wvalid;
	reg         s_axi_bready, s_axi_arvalid, s_axi_rready;
	reg         uart1Irq, uart2Irq;
	reg  [5:0]  s_axi_awaddr, s_axi_araddr;
	reg  [31:0] s_axi_wdata, rd;
	reg  [3:0]  s_axi_wstrb;
	reg  [1:0]  rs, bs;
	wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire        s_axi_rvalid, alarm_out_n, wdIrq, irq;
	wire [1:0]  s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [7:0]  promptCnt_q;
	integer     n_fail, n_tests;
	inactivity_watchdog_timer #(.TICK_CYCLES(TICK)) dut (.sys_clk, .resetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .uart1Irq, .uart2Irq, .alarm_out_n, .wdIrq, .irq);
	host_alarm_sink host (.sys_clk, .resetn, .alarm_out_n, .wdIrq,
		.promptCnt_q);
	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	task chk(input string what, input [31:0] seen, input [31:0] exp);
	begin
		n_tests = n_tests + 1;
		if (seen !== exp)
		begin
			n_fail = n_fail + 1;
			$display("MISMATCH %0s exp %h seen %h", what, exp, seen);
		end
	end
	endtask
	task close_out;
	begin
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
	endtask
	// Each half released once taken; ready raised once the answer shows
	task wr(input [5:0] a, input [31:0] d);
	begin
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do
		begin
			@(posedge sys_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while (s_axi_awvalid || s_axi_wvalid);
		do @(posedge sys_clk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b1;
		do @(posedge sys_clk); while (!s_axi_bvalid);
		bs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	end
	endtask
	task rdr(input [5:0] a);
	begin
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge sys_clk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge sys_clk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b1;
		do @(posedge sys_clk); while (!s_axi_rvalid);
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	end
	endtask
	// Alarm must stay high until k minutes, then fall
	task wait_alarm(input integer k);
	begin
		repeat (k * TICK - 5) @(posedge sys_clk);
		chk("early", alarm_out_n, 1);
		repeat (10) @(posedge sys_clk);
		chk("late", alarm_out_n, 0);
	end
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task t_reset;
	begin
		rdr(6'h00);
		chk("timeout", rd, 0);
		rdr(6'h04);
		chk("mask", rd, 0);
		rdr(6'h08);
		chk("status", rd, 1);
		chk("alarm", alarm_out_n, 1);
		rdr(6'h0c);
		chk("resv", rs, 2);
		chk("resv data", rd, 0);
		wr(6'h0c, 32'hff);
		chk("resv wr", bs, 2);
	end
	endtask
	task t_fields;
	begin
		wr(6'h04, 32'hff);
		chk("okay", bs, 0);
		rdr(6'h04);
		chk("maskbits", rd, 32'h0c);
		wr(6'h08, 32'h0);
		rdr(6'h08);
		chk("status ro", rd, 1);
		wr(6'h00, 32'h1ff);
		rdr(6'h00);
		chk("width", rd, 32'hff);
		wr(6'h01, 32'h05);
		chk("misaligned", bs, 2);
		s_axi_wstrb <= 4'he;
		wr(6'h00, 32'h05);
		s_axi_wstrb <= 4'hf;
		rdr(6'h00);
		chk("kept", rd, 32'hff);
		rdr(6'h02);
		chk("misread", rs, 2);
	end
	endtask
	// Expiry, then interrupt masked, unmasked and cleared
	task t_expire;
	begin
		wr(6'h04, 32'h0);
		wr(6'h00, 32'h2);
		wait_alarm(2);
		rdr(6'h08);
		chk("expired", rd, 0);
		chk("prompt", wdIrq, 1);
		wr(6'h14, 32'h0);
		chk("masked", irq, 0);
		wr(6'h14, 32'h1);
		chk("raised", irq, 1);
		wr(6'h10, 32'h1);
		chk("cleared", irq, 0);
	end
	endtask
	// Release by write, then reload in mid-count
	task t_rewrite;
	begin
		wr(6'h00, 32'h3);
		chk("release", alarm_out_n, 1);
		rdr(6'h08);
		chk("reinit", rd, 1);
		repeat (2 * TICK) @(posedge sys_clk);
		wr(6'h00, 32'h3);
		wait_alarm(3);
	end
	endtask
	task t_stop;
	begin
		wr(6'h00, 32'h1);
		wr(6'h00, 32'h0);
		repeat (3 * TICK) @(posedge sys_clk);
		chk("stopped", alarm_out_n, 1);
	end
	endtask
	// Pulse one serial request over four minutes of a two-minute count
	task t_trigger(input [7:0] m, input sel, input exp);
	integer i;
	begin
		wr(6'h04, {24'h0, m});
		wr(6'h00, 32'h2);
		for (i = 0; i < 8; i = i + 1)
		begin
			@(posedge sys_clk);
			uart1Irq <= !sel;
			uart2Irq <= sel;
			@(posedge sys_clk);
			uart1Irq <= 1'b0;
			uart2Irq <= 1'b0;
			repeat (8) @(posedge sys_clk);
		end
		chk("alive", alarm_out_n, exp);
		wr(6'h00, 32'h0);
	end
	endtask
	initial
	begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	initial
	begin
		#2000000;
		n_fail = n_fail + 1;
		close_out;
	end
	initial
	begin
		{n_fail, n_tests} = 0;
		{resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, uart1Irq, uart2Irq} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
		s_axi_wstrb = 4'hf;
		repeat (6) @(posedge sys_clk);
		resetn <= 1'b1;
		t_reset;
		t_fields;
		t_expire;
		t_rewrite;
		t_stop;
		t_trigger(8'h04, 1'b0, 1'b1);
		t_trigger(8'h08, 1'b0, 1'b0);
		t_trigger(8'h08, 1'b1, 1'b1);
		t_trigger(8'h04, 1'b1, 1'b0);
		chk("prompts", promptCnt_q, 4);
		close_out;
	end
endmodule // test_inactivity_watchdog_timer
